// >>> design/slsq_top.sv
// Status LED sequencer: drives one tri-colour LED from scanner condition.
// Assumes all inputs synchronous to MCLK; decoder results are pulses.
// Contract
// RL1: Idle untriggered normal: blink yellow.
// RL2: Laser on and triggered or continuous: solid yellow.
// RL3: Triggered mode: yellow lasts exactly while trigger held.
// RL4: Trigger ends with good decode: green half second.
// RL5: Failed or invalid decode: solid red half second.
// RL6: After result, back to blinking yellow idle.
// RL7: Setup mode cycles red, yellow, green repeatedly.
// RL8: Failure: red held extended, or blinking red.
// RL9: Continuous mode ignores hardware and serial triggers.
// RL10: Continuous: blink yellow five seconds, then solid.
// RL11: Continuous: green half second per good decode.
// RL12: Continuous mode never shows red no-read; entered during no-read, red still shows for one cycle.
// RL13: Tick counters time all; failure has top priority.
`timescale 1ns/1ps
`include "slsq_cfg.svh"
module slsq_top #(
    parameter int unsigned TICK_CYCLES = `SLSQ_TICK_CYCLES,
    parameter int unsigned RESULT_TICKS = `SLSQ_MS_TO_TICKS(`SLSQ_RESULT_MS),
    parameter int unsigned WARMUP_TICKS = `SLSQ_MS_TO_TICKS(`SLSQ_WARMUP_MS),
    parameter int unsigned BLINK_TICKS = `SLSQ_MS_TO_TICKS(`SLSQ_BLINK_MS),
    parameter int unsigned SETUP_TICKS =
        `SLSQ_MS_TO_TICKS(`SLSQ_SETUP_STEP_MS),
    parameter int unsigned FAIL_TICKS = `SLSQ_MS_TO_TICKS(`SLSQ_FAIL_HOLD_MS)
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic CONT_MODE,
    input wire logic SETUP_MODE,
    input wire logic TRIG_SRC_SERIAL,
    input wire logic TRIG_HW,
    input wire logic TRIG_SER_ON,
    input wire logic TRIG_SER_OFF,
    input wire logic LASER_ON,
    input wire logic DEC_GOOD,
    input wire logic DEC_FAIL,
    input wire logic INVALID_SYMBOL_FLAG,
    input wire logic FAULT_HARD,
    input wire logic FAULT_SPEC,
    output logic LED_RED,
    output logic LED_GREEN,
    output logic LED_YELLOW
);
    localparam int unsigned TW = `SLSQ_TMR_W;
    localparam int unsigned TMAX = (1 << TW) - 1;

    // Every interval must be at least one tick and fit the timers
    if (RESULT_TICKS < 1 || RESULT_TICKS > TMAX ||
        WARMUP_TICKS < 1 || WARMUP_TICKS > TMAX ||
        BLINK_TICKS < 1 || BLINK_TICKS > TMAX ||
        SETUP_TICKS < 1 || SETUP_TICKS > TMAX ||
        FAIL_TICKS < 1 || FAIL_TICKS > TMAX) begin : g_bad_ticks
        $error("slsq_top: tick interval out of range");
    end

    slsq_pkg::slsq_state_type state_r;
    slsq_pkg::slsq_state_type state_nxt;
    slsq_pkg::slsq_phase_type phase_r;
    slsq_pkg::slsq_phase_type phase_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic [TW-1:0] blink_cnt_r;
    logic [TW-1:0] blink_cnt_nxt;
    logic [TW-1:0] setup_cnt_r;
    logic [TW-1:0] setup_cnt_nxt;
    logic [TW-1:0] fail_hold_r;
    logic [TW-1:0] fail_hold_nxt;
    logic blink_r;
    logic blink_nxt;
    logic trig_ser_r;
    logic trig_ser_nxt;
    logic good_seen_r;
    logic good_seen_nxt;
    logic bad_seen_r;
    logic bad_seen_nxt;
    logic led_red_r;
    logic led_red_nxt;
    logic led_green_r;
    logic led_green_nxt;
    logic led_yellow_r;
    logic led_yellow_nxt;
    logic tick;
    logic trig_act;
    logic fail_hard_act;
    logic step;

    // Timer reached its last tick; shared by every interval check except the failure hold
    function automatic logic last_tick(input logic [TW-1:0] cnt,
                                       input int unsigned ticks);
        last_tick = (cnt == TW'(ticks - 1));
    endfunction

    // Millisecond tick feeding every interval
    slsq_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .tick(tick)
    );

    assign step = CE & tick;

    // Trigger source: photoeye level or serial on/off characters
    always_comb begin
        trig_ser_nxt = trig_ser_r;
        if (CE) begin
            if (CONT_MODE || !TRIG_SRC_SERIAL) begin
                trig_ser_nxt = 1'b0; // RL9
            end else if (TRIG_SER_ON) begin
                trig_ser_nxt = 1'b1; // Set wins over a same-cycle off
            end else if (TRIG_SER_OFF) begin
                trig_ser_nxt = 1'b0;
            end
        end
    end

    // Continuous mode masks both trigger paths
    assign trig_act = !CONT_MODE &&
        (TRIG_SRC_SERIAL ? trig_ser_r : TRIG_HW); // RL9

    // Hard failure holds red for a minimum time after it clears
    assign fail_hard_act = FAULT_HARD || (fail_hold_r != '0); // RL8

    always_comb begin
        fail_hold_nxt = fail_hold_r;
        if (CE) begin
            if (FAULT_HARD) begin
                fail_hold_nxt = TW'(FAIL_TICKS); // RL8
            end else if (tick && fail_hold_r != '0) begin
                fail_hold_nxt = fail_hold_r - 1'b1;
            end
        end
    end

    // Blink phase shared by idle, warm-up and soft failure
    always_comb begin
        blink_cnt_nxt = blink_cnt_r;
        blink_nxt = blink_r;
        if (step) begin
            if (last_tick(blink_cnt_r, BLINK_TICKS)) begin
                blink_cnt_nxt = '0;
                blink_nxt = !blink_r; // RL13
            end else begin
                blink_cnt_nxt = blink_cnt_r + 1'b1;
            end
        end
    end

    // Setup colour rotation; restarts at red whenever setup is left
    always_comb begin
        setup_cnt_nxt = setup_cnt_r;
        phase_nxt = phase_r;
        if (CE) begin
            if (!SETUP_MODE) begin
                setup_cnt_nxt = '0;
                phase_nxt = slsq_pkg::PH_RED;
            end else if (tick) begin
                if (last_tick(setup_cnt_r, SETUP_TICKS)) begin
                    setup_cnt_nxt = '0;
                    unique case (phase_r) // RL7
                        slsq_pkg::PH_RED: phase_nxt = slsq_pkg::PH_YEL;
                        slsq_pkg::PH_YEL: phase_nxt = slsq_pkg::PH_GRN;
                        slsq_pkg::PH_GRN: phase_nxt = slsq_pkg::PH_RED;
                        default: phase_nxt = slsq_pkg::PH_RED;
                    endcase
                end else begin
                    setup_cnt_nxt = setup_cnt_r + 1'b1;
                end
            end
        end
    end

    // Main sequence; timer restarts on every state change
    always_comb begin
        state_nxt = state_r;
        good_seen_nxt = good_seen_r;
        bad_seen_nxt = bad_seen_r;
        if (CE) begin
            unique case (state_r)
                slsq_pkg::ST_IDLE: begin
                    good_seen_nxt = 1'b0;
                    bad_seen_nxt = 1'b0;
                    if (CONT_MODE) begin
                        state_nxt = slsq_pkg::ST_WARM; // RL10
                    end else if (trig_act) begin
                        state_nxt = slsq_pkg::ST_TRIG; // RL6
                    end
                end
                slsq_pkg::ST_TRIG: begin
                    // Results are collected while the trigger is held
                    good_seen_nxt = good_seen_r | DEC_GOOD;
                    bad_seen_nxt = bad_seen_r | DEC_FAIL |
                        INVALID_SYMBOL_FLAG;
                    if (CONT_MODE) begin
                        state_nxt = slsq_pkg::ST_WARM;
                    end else if (!trig_act) begin // RL3
                        // Red unless a clean good read was seen
                        if ((good_seen_r | DEC_GOOD) && !(bad_seen_r |
                            DEC_FAIL | INVALID_SYMBOL_FLAG)) begin
                            state_nxt = slsq_pkg::ST_GOOD; // RL4
                        end else begin
                            state_nxt = slsq_pkg::ST_NOREAD; // RL5
                        end
                    end
                end
                slsq_pkg::ST_GOOD: begin
                    if (tick && last_tick(tmr_r, RESULT_TICKS)) begin
                        state_nxt = CONT_MODE ? slsq_pkg::ST_READ :
                            slsq_pkg::ST_IDLE; // RL11
                    end
                end
                slsq_pkg::ST_NOREAD: begin
                    if (CONT_MODE) begin
                        state_nxt = slsq_pkg::ST_WARM; // RL12
                    end else if (tick && last_tick(tmr_r, RESULT_TICKS)) begin
                        state_nxt = slsq_pkg::ST_IDLE; // RL6
                    end
                end
                slsq_pkg::ST_WARM: begin
                    if (!CONT_MODE) begin
                        state_nxt = slsq_pkg::ST_IDLE;
                    end else if (tick && last_tick(tmr_r, WARMUP_TICKS)) begin
                        state_nxt = slsq_pkg::ST_READ; // RL10
                    end
                end
                slsq_pkg::ST_READ: begin
                    if (!CONT_MODE) begin
                        state_nxt = slsq_pkg::ST_IDLE;
                    end else if (DEC_GOOD) begin
                        state_nxt = slsq_pkg::ST_GOOD; // RL11
                    end
                end
                default: state_nxt = slsq_pkg::ST_IDLE;
            endcase
        end
    end

    // Interval timer counts ticks spent in the current state
    always_comb begin
        tmr_nxt = tmr_r;
        if (CE) begin
            if (state_nxt != state_r) begin
                tmr_nxt = '0;
            end else if (tick && tmr_r != TW'(TMAX)) begin
                tmr_nxt = tmr_r + 1'b1; // RL13
            end
        end
    end

    // LED colour; failure beats setup, setup beats the sequence
    always_comb begin
        led_red_nxt = 1'b0;
        led_green_nxt = 1'b0;
        led_yellow_nxt = 1'b0;
        if (fail_hard_act) begin
            led_red_nxt = 1'b1; // RL13
        end else if (FAULT_SPEC) begin
            led_red_nxt = blink_r; // RL8
        end else if (SETUP_MODE) begin
            led_red_nxt = (phase_r == slsq_pkg::PH_RED); // RL7
            led_yellow_nxt = (phase_r == slsq_pkg::PH_YEL);
            led_green_nxt = (phase_r == slsq_pkg::PH_GRN);
        end else begin
            unique case (state_r)
                slsq_pkg::ST_IDLE: led_yellow_nxt = blink_r; // RL1
                slsq_pkg::ST_WARM: led_yellow_nxt = blink_r; // RL10
                // Laser off while armed falls back to the idle blink
                slsq_pkg::ST_TRIG:
                    led_yellow_nxt = LASER_ON | blink_r; // RL2
                slsq_pkg::ST_READ:
                    led_yellow_nxt = LASER_ON | blink_r; // RL2
                slsq_pkg::ST_GOOD: led_green_nxt = 1'b1; // RL4
                slsq_pkg::ST_NOREAD: led_red_nxt = 1'b1; // RL5
                default: led_yellow_nxt = blink_r;
            endcase
        end
        if (!CE) begin
            led_red_nxt = led_red_r;
            led_green_nxt = led_green_r;
            led_yellow_nxt = led_yellow_r;
        end
    end

    // All state registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_r <= slsq_pkg::ST_IDLE;
            phase_r <= slsq_pkg::PH_RED;
            tmr_r <= '0;
            blink_cnt_r <= '0;
            setup_cnt_r <= '0;
            fail_hold_r <= '0;
            blink_r <= 1'b0;
            trig_ser_r <= 1'b0;
            good_seen_r <= 1'b0;
            bad_seen_r <= 1'b0;
            led_red_r <= 1'b0;
            led_green_r <= 1'b0;
            led_yellow_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            tmr_r <= tmr_nxt;
            blink_cnt_r <= blink_cnt_nxt;
            setup_cnt_r <= setup_cnt_nxt;
            fail_hold_r <= fail_hold_nxt;
            blink_r <= blink_nxt;
            trig_ser_r <= trig_ser_nxt;
            good_seen_r <= good_seen_nxt;
            bad_seen_r <= bad_seen_nxt;
            led_red_r <= led_red_nxt;
            led_green_r <= led_green_nxt;
            led_yellow_r <= led_yellow_nxt;
        end
    end

    assign LED_RED = led_red_r;
    assign LED_GREEN = led_green_r;
    assign LED_YELLOW = led_yellow_r;

    // Checks on the indication sequence
    property p_idle_blink;
        @(posedge MCLK) disable iff (RST)
        (CE && state_r == slsq_pkg::ST_IDLE && !fail_hard_act &&
         !FAULT_SPEC && !SETUP_MODE) |=>
        (LED_YELLOW == $past(blink_r)) && !LED_RED && !LED_GREEN;
    endproperty
    a_idle_blink: assert property (p_idle_blink) // RL1
        else $error("idle LED is not blinking yellow");

    property p_solid_yellow;
        @(posedge MCLK) disable iff (RST)
        (CE && LASER_ON && !fail_hard_act && !FAULT_SPEC && !SETUP_MODE &&
         (state_r == slsq_pkg::ST_TRIG || state_r == slsq_pkg::ST_READ))
        |=> LED_YELLOW && !LED_RED && !LED_GREEN;
    endproperty
    a_solid_yellow: assert property (p_solid_yellow) // RL2
        else $error("reading LED is not solid yellow");

    property p_trig_hold;
        @(posedge MCLK) disable iff (RST)
        (CE && !CONT_MODE && state_r == slsq_pkg::ST_TRIG) |=>
        ((state_r == slsq_pkg::ST_TRIG) == $past(trig_act));
    endproperty
    a_trig_hold: assert property (p_trig_hold) // RL3
        else $error("trigger state does not follow the trigger");

    property p_good_time;
        @(posedge MCLK) disable iff (RST)
        (CE && !CONT_MODE && state_r == slsq_pkg::ST_TRIG && !trig_act &&
         (good_seen_r || DEC_GOOD) && !DEC_FAIL && !INVALID_SYMBOL_FLAG &&
         !bad_seen_r)
        |=> (state_r == slsq_pkg::ST_GOOD) && tmr_r == '0;
    endproperty
    a_good_time: assert property (p_good_time) // RL4
        else $error("good read did not start the green interval");

    property p_noread_end;
        @(posedge MCLK) disable iff (RST)
        (CE && tick && !CONT_MODE && state_r == slsq_pkg::ST_NOREAD &&
         tmr_r == TW'(RESULT_TICKS - 1)) |=> state_r == slsq_pkg::ST_IDLE;
    endproperty
    a_noread_end: assert property (p_noread_end) // RL6
        else $error("no read did not return to idle on time");

    property p_setup_red;
        @(posedge MCLK) disable iff (RST)
        (CE && SETUP_MODE && !fail_hard_act && !FAULT_SPEC &&
         phase_r == slsq_pkg::PH_RED) |=>
        LED_RED && !LED_GREEN && !LED_YELLOW;
    endproperty
    a_setup_red: assert property (p_setup_red) // RL7
        else $error("setup red step shows wrong colour");

    property p_fail_hold;
        @(posedge MCLK) disable iff (RST)
        (CE && FAULT_HARD) ##1 (CE && !FAULT_HARD) |=>
        LED_RED && !LED_GREEN && !LED_YELLOW;
    endproperty
    a_fail_hold: assert property (p_fail_hold) // RL8
        else $error("hard failure red not held");

    property p_ser_ignored;
        @(posedge MCLK) disable iff (RST)
        (CE && CONT_MODE) |=> !trig_ser_r;
    endproperty
    a_ser_ignored: assert property (p_ser_ignored) // RL9
        else $error("serial trigger taken in continuous mode");

    property p_warm_end;
        @(posedge MCLK) disable iff (RST)
        (CE && tick && CONT_MODE && state_r == slsq_pkg::ST_WARM &&
         tmr_r == TW'(WARMUP_TICKS - 1)) |=> state_r == slsq_pkg::ST_READ;
    endproperty
    a_warm_end: assert property (p_warm_end) // RL10
        else $error("warm-up did not end on time");

    property p_cont_good;
        @(posedge MCLK) disable iff (RST)
        (CE && CONT_MODE && DEC_GOOD && state_r == slsq_pkg::ST_READ) |=>
        state_r == slsq_pkg::ST_GOOD;
    endproperty
    a_cont_good: assert property (p_cont_good) // RL11
        else $error("continuous good read not shown");

    property p_cont_no_red;
        @(posedge MCLK) disable iff (RST)
        (CE && CONT_MODE && !fail_hard_act && !FAULT_SPEC && !SETUP_MODE &&
         state_r != slsq_pkg::ST_NOREAD) |=> !LED_RED;
    endproperty
    a_cont_no_red: assert property (p_cont_no_red) // RL12
        else $error("red shown in continuous mode");

    property p_spec_blink;
        @(posedge MCLK) disable iff (RST)
        (CE && FAULT_SPEC && !fail_hard_act) |=>
        (LED_RED == $past(blink_r)) && !LED_GREEN && !LED_YELLOW;
    endproperty
    a_spec_blink: assert property (p_spec_blink) // RL13
        else $error("soft failure does not take priority");

endmodule // slsq_top

// >>> design/slsq_cfg.svh
// Timing constants for the status LED sequencer.
// Assumes a 100 MHz system clock and a 1 ms housekeeping tick.
`ifndef SLSQ_CFG_SVH
`define SLSQ_CFG_SVH

// System clock period in ns
`define SLSQ_CLK_PERIOD_NS 10
// Housekeeping tick period in us
`define SLSQ_TICK_US 1000
// Clock cycles per tick
`define SLSQ_TICK_CYCLES ((`SLSQ_TICK_US * 1000) / `SLSQ_CLK_PERIOD_NS)
// Milliseconds to whole ticks
`define SLSQ_MS_TO_TICKS(ms) (((ms) * 1000) / `SLSQ_TICK_US)

// Good read and no read indication time, ms
`define SLSQ_RESULT_MS 500
// Continuous mode warm-up blink time, ms
`define SLSQ_WARMUP_MS 5000
// Half period of every blink, ms
`define SLSQ_BLINK_MS 250
// Time spent on each colour of the setup cycle, ms
`define SLSQ_SETUP_STEP_MS 333
// Least time a hard failure holds the LED red, ms
`define SLSQ_FAIL_HOLD_MS 3000
// Width of all tick timers
`define SLSQ_TMR_W 13

`endif

// >>> design/slsq_pkg.sv
// Types shared by the status LED sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package slsq_pkg;

    // Main indication state, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_TRIG   = 6'h02,
        ST_GOOD   = 6'h04,
        ST_NOREAD = 6'h08,
        ST_WARM   = 6'h10,
        ST_READ   = 6'h20
    } slsq_state_type;

    // Colour step of the setup cycle, one-hot
    typedef enum logic [2:0] {
        PH_RED = 3'h1,
        PH_YEL = 3'h2,
        PH_GRN = 3'h4
    } slsq_phase_type;

endpackage

// >>> design/slsq_tick.sv
// Tick prescaler for the status LED sequencer.
// Assumes a free running clock; ce freezes the count.
`timescale 1ns/1ps
module slsq_tick #(
    parameter int unsigned CYCLES = 100000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    output logic tick
);
    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    if (CYCLES < 2) begin : g_bad_cycles
        $error("slsq_tick: CYCLES must be at least 2");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // Wrap at CYCLES-1 and pulse once per wrap
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = tick_r;
        if (ce) begin
            if (cnt_r == CW'(CYCLES - 1)) begin
                cnt_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
                tick_nxt = 1'b0;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // slsq_tick

// >>> sim/slsq_eye_led.sv
// Far side model: trigger photoeye and the tri-colour status LED.
// Assumes the bench moves box_in off the rising edge of mclk.
`timescale 1ns/1ps
module slsq_eye_led (
    input wire logic mclk,
    input wire logic box_in,
    input wire logic [1:0] eye_lag,
    input wire logic led_r,
    input wire logic led_g,
    input wire logic led_y,
    output logic eye_out,
    output logic [1:0] colour,
    output logic clash
);
    logic [3:0] line_r = 4'h0;

    // Photoeye output lags the box by eye_lag plus one cycles, as slow eyes do
    always @(posedge mclk) begin
        line_r <= {line_r[2:0], box_in};
    end
    assign eye_out = line_r[eye_lag];

    // Seen colour: 0 off, 1 red, 2 yellow, 3 green
    assign colour = led_g ? 2'h3 : (led_y ? 2'h2 : {1'b0, led_r});
    // A single LED cannot show two colours at once
    assign clash = (int'(led_r) + int'(led_g) + int'(led_y)) > 1;
endmodule // slsq_eye_led

// >>> sim/tb_top.sv
// Self-checking bench for the status LED sequencer.
// Assumes short tick counts: one tick is 4 clocks, results 5 ticks.
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cont = 1'b0;
    logic setup = 1'b0;
    logic src_ser = 1'b0;
    logic ser_on = 1'b0;
    logic ser_off = 1'b0;
    logic laser = 1'b1;
    logic dec_good = 1'b0;
    logic dec_fail = 1'b0;
    logic inval = 1'b0;
    logic f_hard = 1'b0;
    logic f_spec = 1'b0;
    logic box = 1'b0;
    logic [1:0] lag = 2'h0;
    logic trig_hw, led_r, led_g, led_y, clash;
    logic [1:0] colour;
    logic [3:0] seen;
    int err_count = 0;
    int compares = 0;
    int n;

    slsq_top #(.TICK_CYCLES(4), .RESULT_TICKS(5), .WARMUP_TICKS(20),
        .BLINK_TICKS(2), .SETUP_TICKS(3), .FAIL_TICKS(6)) u_slsq_top (
        .MCLK(mclk), .RST(rst), .CE(ce), .CONT_MODE(cont),
        .SETUP_MODE(setup), .TRIG_SRC_SERIAL(src_ser), .TRIG_HW(trig_hw),
        .TRIG_SER_ON(ser_on), .TRIG_SER_OFF(ser_off), .LASER_ON(laser),
        .DEC_GOOD(dec_good), .DEC_FAIL(dec_fail),
        .INVALID_SYMBOL_FLAG(inval), .FAULT_HARD(f_hard),
        .FAULT_SPEC(f_spec), .LED_RED(led_r), .LED_GREEN(led_g),
        .LED_YELLOW(led_y));

    slsq_eye_led u_slsq_eye_led (.mclk(mclk), .box_in(box), .eye_lag(lag),
        .led_r(led_r), .led_g(led_g), .led_y(led_y), .eye_out(trig_hw),
        .colour(colour), .clash(clash));

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // Colours seen over k cycles as a mask; two LEDs lit is always wrong
    task automatic watch(input int k, output logic [3:0] m);
        m = 4'h0;
        repeat (k) begin
            cyc(1);
            m[colour] = 1'b1;
            check({7'h00, clash}, 8'h00);
        end
    endtask

    // Bounded wait for a colour; running out ends the run
    task automatic wait_col(input logic [1:0] c, input int bound);
        for (int i = 0; i < bound && colour !== c; i++) cyc(1);
        if (colour !== c) begin
            check(8'hFF, {6'h00, c});
            give_verdict();
        end
    endtask

    // Length in cycles of one showing of colour c
    task automatic dur(input logic [1:0] c, output int k);
        wait_col(c, 10);
        k = 0;
        while (colour === c && k < 300) begin
            cyc(1);
            k++;
        end
    endtask

    // One triggered read: start, decoder pulses, stop, then the result
    task automatic one_read(input logic ser, input logic g, input logic f,
        input logic v, input logic [1:0] c);
        if (ser) ser_on = 1'b1;
        else box = 1'b1;
        cyc(1);
        ser_on = 1'b0;
        cyc(5);
        watch(20, seen);
        check(seen, 4'b0100);
        dec_good = g;
        dec_fail = f;
        inval = v;
        cyc(1);
        {dec_good, dec_fail, inval} = 3'h0;
        cyc(3);
        if (ser) ser_off = 1'b1;
        else box = 1'b0;
        cyc(1);
        ser_off = 1'b0;
        dur(c, n);
        check({7'h00, n >= 16 && n <= 20}, 8'h01);
        watch(40, seen);
        check(seen, 4'b0101);
    endtask

    // Run cut short if the main sequence hangs
    initial begin
        #200000;
        check(8'h01, 8'h00);
        give_verdict();
    end

    // Main sequence
    initial begin
        cyc(6);
        rst = 1'b0;
        watch(40, seen);
        check(seen, 4'b0101);
        ce = 1'b0;
        n = colour;
        watch(30, seen);
        check(seen, 8'h01 << n);
        ce = 1'b1;
        lag = 2'h0;
        one_read(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
        lag = 2'h2;
        one_read(1'b0, 1'b0, 1'b1, 1'b0, 2'h1);
        lag = 2'h3;
        one_read(1'b0, 1'b1, 1'b0, 1'b1, 2'h1);
        lag = 2'h1;
        one_read(1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
        src_ser = 1'b1;
        box = 1'b1;
        watch(30, seen);
        check(seen, 4'b0101);
        box = 1'b0;
        one_read(1'b1, 1'b1, 1'b0, 1'b0, 2'h3);
        src_ser = 1'b0;
        // Setup rotation, each step three ticks
        setup = 1'b1;
        wait_col(2'h1, 5);
        wait_col(2'h2, 14);
        wait_col(2'h3, 14);
        wait_col(2'h1, 14);
        // Faults override setup
        f_spec = 1'b1;
        cyc(3);
        watch(40, seen);
        check(seen, 4'b0011);
        f_spec = 1'b0;
        f_hard = 1'b1;
        cyc(3);
        watch(20, seen);
        check(seen, 4'b0010);
        setup = 1'b0;
        f_hard = 1'b0;
        dur(2'h1, n);
        check({7'h00, n >= 19 && n <= 27}, 8'h01);
        // Continuous read: warm-up blink, then solid
        cont = 1'b1;
        watch(60, seen);
        check(seen, 4'b0101);
        cyc(30);
        watch(20, seen);
        check(seen, 4'b0100);
        // Laser off while reading falls back to the blink
        laser = 1'b0;
        watch(30, seen);
        check(seen, 4'b0101);
        laser = 1'b1;
        // Serial source selected so the serial path is really masked
        src_ser = 1'b1;
        box = 1'b1;
        ser_on = 1'b1;
        cyc(1);
        ser_on = 1'b0;
        dec_fail = 1'b1;
        cyc(1);
        dec_fail = 1'b0;
        inval = 1'b1;
        cyc(1);
        inval = 1'b0;
        box = 1'b0;
        watch(30, seen);
        check(seen, 4'b0100);
        dec_good = 1'b1;
        cyc(1);
        dec_good = 1'b0;
        dur(2'h3, n);
        check({7'h00, n >= 16 && n <= 20}, 8'h01);
        watch(20, seen);
        check(seen, 4'b0100);
        give_verdict();
    end
endmodule // tb_top
